// ---- src/p0g_cfg.svh ----
/*
 * Constants for the port 0 block: register offsets, field masks,
 * reset values and pin layout.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef P0G_CFG_SVH
`define P0G_CFG_SVH

// Register bus geometry
`define P0G_ADDR_W     4
`define P0G_DATA_W     8

// Register offsets
`define P0G_OFF_DATA   4'h0
`define P0G_OFF_DIR    4'h1
`define P0G_OFF_PUL    4'h2
`define P0G_OFF_AIDR   4'h3
`define P0G_OFF_STAT   4'h4

// Implemented bits of each register
`define P0G_PORT_MASK  8'hf0
`define P0G_AIDR_MASK  8'h33

// Reset values
`define P0G_RST_DATA   8'h00
`define P0G_RST_DIR    8'h00
`define P0G_RST_PUL    8'h00
`define P0G_RST_AIDR   8'h00

// Pin layout: four pins on data bits 7..4
`define P0G_PINS       4
`define P0G_PIN_LSB    4
`define P0G_PIN_MSB    7

// Analog-disable bits of pins 7, 6, 5, 4
`define P0G_AIDR_P7    5
`define P0G_AIDR_P6    4
`define P0G_AIDR_P5    1
`define P0G_AIDR_P4    0

// Pins whose input survives isolation (pin 5 carries the interrupt)
`define P0G_IRQ_KEEP   4'h2

// Status register fields
`define P0G_STAT_MODE_LSB 0
`define P0G_STAT_MODE_MSB 1

`endif

// ---- src/p0g_pkg.sv ----
/*
 * Types shared by the port 0 modules.
 * Assumes the configuration header is on the include path.
 */
`include "p0g_cfg.svh"

package p0g_pkg;
	typedef logic [`P0G_ADDR_W-1:0] p0g_addr_t;     // Register address
	typedef logic [`P0G_DATA_W-1:0] p0g_byte_t;     // Register data
	typedef logic [`P0G_PINS-1:0]   p0g_pins_t;     // One bit per pin

	// Register selected by an address
	typedef enum logic [2:0] {
		P0G_REG_DATA,
		P0G_REG_DIR,
		P0G_REG_PUL,
		P0G_REG_AIDR,
		P0G_REG_STAT,
		P0G_REG_NONE
	} p0g_reg_t;

	// Pad operating mode
	typedef enum logic [1:0] {
		P0G_MODE_RUN,
		P0G_MODE_HOLD,
		P0G_MODE_ISOLATE
	} p0g_mode_t;
endpackage : p0g_pkg

// ---- src/p0g_pad_if.sv ----
/*
 * Bundle between the register block and the pad control.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface p0g_pad_if;
	import p0g_pkg::*;
	p0g_pins_t latch;      // Output latch per pin
	p0g_pins_t dir;        // Direction per pin
	p0g_pins_t pul;        // Pull-up request per pin
	p0g_pins_t dig_en;     // Digital input buffer enable
	p0g_pins_t per_oe;     // Peripheral output enable
	p0g_pins_t per_val;    // Peripheral output value
	p0g_pins_t lvl;        // Gated pin level, combinational
	p0g_pins_t pad_out;    // Registered pad value
	p0g_pins_t pad_oe;     // Registered pad enable
	p0g_pins_t pu_en;      // Registered pull-up enable
	p0g_pins_t din;        // Registered input to peripherals
	p0g_pins_t ana;        // Registered analog path enable
	p0g_mode_t mode;       // Registered pad mode

	modport regs (output latch, dir, pul, dig_en, per_oe, per_val,
		input lvl, pad_out, pad_oe, pu_en, din, ana, mode);
	modport pad (input latch, dir, pul, dig_en, per_oe, per_val,
		output lvl, pad_out, pad_oe, pu_en, din, ana, mode);
endinterface : p0g_pad_if

// ---- src/p0g_pad_ctrl.sv ----
/*
 * Pad control for port 0: drive, pull-up, input gating and standby
 * isolation, all outputs registered except the gated level lvl.
 * Assumes pad inputs are synchronous to i_clk.
 */
`timescale 1ns/10ps
`include "p0g_cfg.svh"

module p0g_pad_ctrl #(
	parameter int unsigned            N        = `P0G_PINS,     // Pin count
	parameter logic [`P0G_PINS-1:0]   IRQ_KEEP = `P0G_IRQ_KEEP  // Interrupt pins
) (
	input  wire logic                 i_clk,      // Machine clock
	input  wire logic                 i_nrst,     // Async reset, low
	input  wire logic                 i_standby,  // Stop or watch mode
	input  wire logic                 i_spl,      // Standby pin state bit
	input  wire logic                 i_irq_en,   // Interrupt input enabled
	input  wire p0g_pkg::p0g_pins_t   i_pad_in,   // Pad levels
	p0g_pad_if.pad                    pif         // Register side
);
	import p0g_pkg::*;

	p0g_mode_t mode_d;     // Mode for the next edge
	p0g_pins_t out_d;      // Next pad value
	p0g_pins_t oe_d;       // Next pad enable
	p0g_pins_t pu_d;       // Next pull-up
	p0g_pins_t din_d;      // Next peripheral input
	p0g_pins_t keep;       // Inputs left open in isolation
	p0g_pins_t out_q;      // Pad value
	p0g_pins_t oe_q;       // Pad enable
	p0g_pins_t pu_q;       // Pull-up
	p0g_pins_t din_q;      // Peripheral input
	p0g_pins_t ana_q;      // Analog enable
	p0g_mode_t mode_q;     // Current mode

	// Next state of the pads
	always_comb begin
		keep = i_irq_en ? IRQ_KEEP : '0;
		if (!i_standby) begin
			mode_d = P0G_MODE_RUN;
		end else if (i_spl) begin
			mode_d = P0G_MODE_ISOLATE;                  // [RL14]
		end else begin
			mode_d = P0G_MODE_HOLD;                     // [RL16]
		end
		// Peripheral wins over latch and direction
		out_d = (pif.per_oe & pif.per_val) | (~pif.per_oe & pif.latch);  // [RL2] [RL7] [RL21]
		oe_d  = pif.per_oe | pif.dir;                   // [RL1] [RL4] [RL3]
		// Buffer gated by analog disable; blocked while isolated except kept interrupt pins
		pif.lvl = i_pad_in & pif.dig_en;                // [RL10]
		unique case (mode_d)
			P0G_MODE_RUN: begin
			end
			P0G_MODE_HOLD: begin
				out_d = out_q;                          // [RL16]
				oe_d  = oe_q;
			end
			P0G_MODE_ISOLATE: begin
				oe_d    = '0;                           // [RL14]
				pif.lvl = pif.lvl & keep;               // [RL14] [RL15]
			end
		endcase
		din_d = pif.lvl;
		// No pull-up against a driven low; none in isolation
		pu_d = pif.pul & ~(oe_d & ~out_d);              // [RL20]
		if (mode_d == P0G_MODE_ISOLATE) begin
			pu_d = '0;
		end
	end

	// Pad registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			out_q  <= '0;
			oe_q   <= '0;
			pu_q   <= '0;
			din_q  <= '0;
			ana_q  <= '1;
			mode_q <= P0G_MODE_RUN;
		end else begin
			out_q  <= out_d;
			oe_q   <= oe_d;
			pu_q   <= pu_d;
			din_q  <= din_d;
			ana_q  <= ~pif.dig_en;                      // [RL10]
			mode_q <= mode_d;
		end
	end

	assign pif.pad_out = out_q;
	assign pif.pad_oe  = oe_q;
	assign pif.pu_en   = pu_q;
	assign pif.din     = din_q;
	assign pif.ana     = ana_q;
	assign pif.mode    = mode_q;
endmodule : p0g_pad_ctrl

// ---- src/p0g_port0.sv ----
/*
 * Port 0 general-purpose I/O with analog sharing: register block,
 * read return paths and the pad control instance.
 * Assumes a single-cycle strobe bus master on i_clk, pad inputs
 * already synchronous, and standby controls from the system block.
 */
`timescale 1ns/10ps
`include "p0g_cfg.svh"

// Functional notes
// RL1: Direction one makes the pin output
// RL2: Output pin drives its latch bit
// RL3: Data write updates latch; inputs stay undriven
// RL4: Direction zero makes the pin input
// RL5: Normal read of output returns latch
// RL6: Input read gives pin; modify-read gives latch
// RL7: Peripheral output enable takes the pin
// RL8: Peripheral-driven pin reads level; modify-read latch
// RL9: Peripheral input pin still reads level
// RL10: Analog disable one enables digital input
// RL11: Data bits 7..4; disable bits 5,4,1,0
// RL12: Reset clears direction, pins input
// RL13: Reset clears analog disable register
// RL14: Isolation floats pins, blocks inputs low
// RL15: Enabled interrupt pin keeps input open
// RL16: Standby without isolation holds pin state
// RL17: Analog use needs software setup first
// RL18: Digital peripheral input needs disable set
// RL19: Software disables peripherals before port use
// RL20: Pull-up drops while pin drives low
// RL21: Peripheral output beats latch and direction
module p0g_port0 (
	input  wire logic                i_clk,          // Machine clock
	input  wire logic                i_nrst,         // Async reset, low
	input  wire p0g_pkg::p0g_addr_t  i_addr,         // Register address
	input  wire p0g_pkg::p0g_byte_t  i_wdata,        // Write data
	input  wire logic                i_wr,           // Write strobe
	input  wire logic                i_rd,           // Read strobe
	input  wire logic                i_rmw,          // Read is modify-read
	output      p0g_pkg::p0g_byte_t  o_rdata,        // Read data, next cycle
	input  wire p0g_pkg::p0g_pins_t  i_pad_in,       // Pad levels, pins 7..4
	output      p0g_pkg::p0g_pins_t  o_pad_out,      // Pad value
	output      p0g_pkg::p0g_pins_t  o_pad_oe,       // Pad enable, high drives
	output      p0g_pkg::p0g_pins_t  o_pullup_en,    // Pull-up connected
	output      p0g_pkg::p0g_pins_t  o_dig_in,       // Input to peripherals
	output      p0g_pkg::p0g_pins_t  o_analog_en,    // Analog path selected
	input  wire p0g_pkg::p0g_pins_t  i_periph_oe,    // Peripheral output enable
	input  wire p0g_pkg::p0g_pins_t  i_periph_val,   // Peripheral output value
	input  wire logic                i_standby,      // Stop or watch mode
	input  wire logic                i_standby_pin_state_bit, // Isolate in standby
	input  wire logic                i_ext_irq_line_5_en      // Pin 5 interrupt on
);
	import p0g_pkg::*;

	// Address decode, used by both write and read paths
	function automatic p0g_reg_t reg_decode(input p0g_addr_t a);
		p0g_reg_t r;
		unique case (a)
			`P0G_OFF_DATA: r = P0G_REG_DATA;
			`P0G_OFF_DIR:  r = P0G_REG_DIR;
			`P0G_OFF_PUL:  r = P0G_REG_PUL;
			`P0G_OFF_AIDR: r = P0G_REG_AIDR;
			`P0G_OFF_STAT: r = P0G_REG_STAT;
			default:       r = P0G_REG_NONE;       // Unmapped
		endcase
		return r;
	endfunction : reg_decode

	// Scatter of analog-disable bits onto pins 7..4
	function automatic p0g_pins_t aidr_pins(input p0g_byte_t a);
		return {a[`P0G_AIDR_P7], a[`P0G_AIDR_P6],
			a[`P0G_AIDR_P5], a[`P0G_AIDR_P4]};        // [RL11]
	endfunction : aidr_pins

	p0g_pad_if pif ();                               // Bundle to pad control

	p0g_reg_t  wr_sel;                              // Register written
	p0g_reg_t  rd_sel;                              // Register read
	p0g_byte_t data_q;                              // Output latch
	p0g_byte_t data_d;
	p0g_byte_t dir_q;                               // Direction
	p0g_byte_t dir_d;
	p0g_byte_t pul_q;                               // Pull-up enable
	p0g_byte_t pul_d;
	p0g_byte_t aidr_q;                              // Analog input disable
	p0g_byte_t aidr_d;
	p0g_byte_t rdata_q;                             // Read return
	p0g_byte_t rdata_d;
	p0g_pins_t pin_view;                            // Normal data read value
	p0g_pins_t use_pin;                             // Pins reading the level
	p0g_byte_t stat_val;                            // Status word

	// Register writes; unimplemented bits stay zero
	always_comb begin
		wr_sel = reg_decode(i_addr);
		data_d = data_q;
		dir_d  = dir_q;
		pul_d  = pul_q;
		aidr_d = aidr_q;
		if (i_wr) begin
			unique case (wr_sel)
				P0G_REG_DATA: data_d = i_wdata & `P0G_PORT_MASK;   // [RL3] [RL11]
				P0G_REG_DIR:  dir_d  = i_wdata & `P0G_PORT_MASK;   // [RL1] [RL4]
				P0G_REG_PUL:  pul_d  = i_wdata & `P0G_PORT_MASK;
				P0G_REG_AIDR: aidr_d = i_wdata & `P0G_AIDR_MASK;   // [RL10] [RL11]
				// Status is read only, unmapped is ignored
				P0G_REG_STAT, P0G_REG_NONE: begin
				end
			endcase
		end
	end

	// Register storage
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			data_q <= `P0G_RST_DATA;
			dir_q  <= `P0G_RST_DIR;                     // [RL12]
			pul_q  <= `P0G_RST_PUL;
			aidr_q <= `P0G_RST_AIDR;                    // [RL13]
		end else begin
			data_q <= data_d;
			dir_q  <= dir_d;
			pul_q  <= pul_d;
			aidr_q <= aidr_d;
		end
	end

	// Feed the pad control
	assign pif.latch   = data_q[`P0G_PIN_MSB:`P0G_PIN_LSB];
	assign pif.dir     = dir_q[`P0G_PIN_MSB:`P0G_PIN_LSB];
	assign pif.pul     = pul_q[`P0G_PIN_MSB:`P0G_PIN_LSB];
	assign pif.dig_en  = aidr_pins(aidr_q);
	assign pif.per_oe  = i_periph_oe;
	assign pif.per_val = i_periph_val;

	// Pad drive, pull-up and gating live here
	p0g_pad_ctrl #(
		.N        (`P0G_PINS),
		.IRQ_KEEP (`P0G_IRQ_KEEP)
	) u_pad (
		.i_clk     (i_clk),
		.i_nrst    (i_nrst),
		.i_standby (i_standby),
		.i_spl     (i_standby_pin_state_bit),
		.i_irq_en  (i_ext_irq_line_5_en),
		.i_pad_in  (i_pad_in),
		.pif       (pif)
	);

	// Read return; zero outside the cycle after a read
	always_comb begin
		rd_sel = reg_decode(i_addr);
		// Input pins and peripheral-driven pins show the level
		use_pin  = ~pif.dir | i_periph_oe;                 // [RL5] [RL8] [RL9]
		pin_view = (use_pin & pif.lvl) | (~use_pin & pif.latch);
		stat_val = '0;
		stat_val[`P0G_STAT_MODE_MSB:`P0G_STAT_MODE_LSB] = pif.mode;
		stat_val[`P0G_PIN_MSB:`P0G_PIN_LSB] = pif.lvl;
		rdata_d = '0;
		if (i_rd) begin
			unique case (rd_sel)
				P0G_REG_DATA: begin
					if (i_rmw) begin
						rdata_d = data_q;                    // [RL6] [RL8] [RL9]
					end else begin
						rdata_d[`P0G_PIN_MSB:`P0G_PIN_LSB] = pin_view;  // [RL5] [RL6]
					end
				end
				P0G_REG_DIR:  rdata_d = dir_q;
				P0G_REG_PUL:  rdata_d = pul_q;
				P0G_REG_AIDR: rdata_d = aidr_q;
				P0G_REG_STAT: rdata_d = stat_val;
				P0G_REG_NONE: rdata_d = '0;                 // Unmapped reads zero
			endcase
		end
	end

	// Read data register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Every output straight from a flip-flop
	assign o_rdata     = rdata_q;
	assign o_pad_out   = pif.pad_out;
	assign o_pad_oe    = pif.pad_oe;
	assign o_pullup_en = pif.pu_en;
	assign o_dig_in    = pif.din;
	assign o_analog_en = pif.ana;

	// Checks on the port behaviour
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	AST_WRITE_LATCH: assert property ( // [RL3]
		(i_wr && i_addr == `P0G_OFF_DATA)
		|=> data_q == ($past(i_wdata) & `P0G_PORT_MASK))
		else $error("data write not latched");

	AST_RMW_READ: assert property ( // [RL6]
		(i_rd && i_rmw && i_addr == `P0G_OFF_DATA)
		|=> o_rdata == $past(data_q))
		else $error("modify-read did not return latch");

	AST_NORMAL_READ: assert property ( // [RL5]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA)
		|=> o_rdata[`P0G_PIN_MSB:`P0G_PIN_LSB] ==
			$past((pif.latch & pif.dir & ~i_periph_oe) |
			(pif.lvl & ~(pif.dir & ~i_periph_oe))))
		else $error("normal read picked wrong source");

	AST_READ_IDLE: assert property (
		!i_rd |=> o_rdata == '0)
		else $error("read data outside read slot");

	AST_DRIVE_EN: assert property ( // [RL1]
		!i_standby |=> o_pad_oe == $past(pif.dir | i_periph_oe))
		else $error("pad enable mismatch");

	AST_DRIVE_VAL: assert property ( // [RL21]
		(!i_standby ##1 !i_standby)
		|-> o_pad_out == $past((i_periph_oe & i_periph_val) |
			(~i_periph_oe & pif.latch)))
		else $error("pad value mismatch");

	AST_ISOLATE: assert property ( // [RL14]
		(i_standby && i_standby_pin_state_bit)
		|=> (o_pad_oe == '0 && (o_dig_in & ~`P0G_IRQ_KEEP) == '0
			&& o_pullup_en == '0))
		else $error("isolation incomplete");

	AST_IRQ_OPEN: assert property ( // [RL15]
		(i_standby && i_standby_pin_state_bit && i_ext_irq_line_5_en)
		|=> o_dig_in[1] == $past(i_pad_in[1] & pif.dig_en[1]))
		else $error("interrupt input blocked");

	AST_HOLD: assert property ( // [RL16]
		(i_standby && !i_standby_pin_state_bit)
		|=> ($stable(o_pad_out) && $stable(o_pad_oe)))
		else $error("pins changed in hold");

	AST_PULLUP_LOW: assert property ( // [RL20]
		(o_pullup_en & o_pad_oe & ~o_pad_out) == '0)
		else $error("pull-up against driven low");

	AST_ANALOG: assert property ( // [RL10]
		1'b1 |=> o_analog_en == ~$past(aidr_pins(aidr_q)))
		else $error("analog select mismatch");

	// Direction write lands on the next edge
	AST_DIR_WRITE: assert property ( // [RL1]
		(i_wr && i_addr == `P0G_OFF_DIR)
		|=> dir_q == ($past(i_wdata) & `P0G_PORT_MASK))
		else $error("direction write not stored");

	// Direction holds between its own writes
	AST_DIR_KEEP: assert property ( // [RL4]
		!(i_wr && i_addr == `P0G_OFF_DIR)
		|=> $stable(dir_q))
		else $error("direction changed without a write");

	// Latch holds between data writes, whatever the pin mode
	AST_LATCH_KEEP: assert property ( // [RL3]
		!(i_wr && i_addr == `P0G_OFF_DATA)
		|=> $stable(data_q))
		else $error("latch changed without a write");

	// Analog disable write keeps only the four wired bits
	AST_AIDR_WRITE: assert property ( // [RL10]
		(i_wr && i_addr == `P0G_OFF_AIDR)
		|=> aidr_q == ($past(i_wdata) & `P0G_AIDR_MASK))
		else $error("analog disable write not stored");

	// Pull-up request write lands on the next edge
	AST_PUL_WRITE: assert property ( // [RL20]
		(i_wr && i_addr == `P0G_OFF_PUL)
		|=> pul_q == ($past(i_wdata) & `P0G_PORT_MASK))
		else $error("pull-up write not stored");

	// Outside standby, with neither direction nor peripheral the pin floats
	AST_INPUT_FLOAT: assert property ( // [RL4]
		(!i_standby && (pif.dir | i_periph_oe) == '0)
		|=> o_pad_oe == '0)
		else $error("input pin driven");

	// A peripheral output turns the driver on outside standby
	AST_PERIPH_OE: assert property ( // [RL7]
		!i_standby
		|=> (~o_pad_oe & $past(i_periph_oe)) == '0)
		else $error("peripheral pin not driven");

	// Outside standby a peripheral's value wins over the latch from the next edge
	AST_PERIPH_VAL: assert property ( // [RL21]
		!i_standby
		|=> ((o_pad_out ^ $past(i_periph_val)) & $past(i_periph_oe)) == '0)
		else $error("peripheral value lost");

	// In run mode only the disable bit gates the buffer
	AST_DIG_IN_RUN: assert property ( // [RL10]
		!i_standby
		|=> o_dig_in == $past(i_pad_in & pif.dig_en))
		else $error("digital input gating wrong");

	// Isolation without the interrupt blocks every input
	AST_IRQ_BLOCK: assert property ( // [RL14]
		(i_standby && i_standby_pin_state_bit && !i_ext_irq_line_5_en)
		|=> o_dig_in == '0)
		else $error("input open during isolation");

	// Plain output pins read back their latch bit
	AST_OUT_READ: assert property ( // [RL5]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA)
		|=> ((o_rdata[`P0G_PIN_MSB:`P0G_PIN_LSB] ^ $past(pif.latch))
			& $past(pif.dir & ~i_periph_oe)) == '0)
		else $error("output pin read not latch");

	// Input pins read back the gated level
	AST_IN_READ: assert property ( // [RL6]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA)
		|=> ((o_rdata[`P0G_PIN_MSB:`P0G_PIN_LSB] ^ $past(pif.lvl))
			& $past(~pif.dir)) == '0)
		else $error("input pin read not level");

	// Peripheral-driven pins read back the level they show
	AST_PERIPH_READ: assert property ( // [RL8]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA)
		|=> ((o_rdata[`P0G_PIN_MSB:`P0G_PIN_LSB] ^ $past(pif.lvl))
			& $past(i_periph_oe)) == '0)
		else $error("peripheral pin read not level");

	// Bits below the pins read zero on a normal read
	AST_LOW_BITS: assert property ( // [RL11]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA)
		|=> o_rdata[`P0G_PIN_LSB-1:0] == '0)
		else $error("unwired data bits read nonzero");

	// Blocked inputs read low while isolated
	AST_ISO_READ: assert property ( // [RL14]
		(i_rd && !i_rmw && i_addr == `P0G_OFF_DATA && i_standby
			&& i_standby_pin_state_bit && !i_ext_irq_line_5_en)
		|=> (o_rdata[`P0G_PIN_MSB:`P0G_PIN_LSB] & $past(~pif.dir | i_periph_oe)) == '0)
		else $error("isolated input read high");
endmodule : p0g_port0

// ---- tb/p0g_board.sv ----
/*
 * Board-side model of the four port 0 pins: resolves each wire from
 * the pad drive, an external source and the internal pull-up.
 * Assumes the bench never drives a pin that the device also drives.
 */
`timescale 1ns/10ps

module p0g_board (
	input  wire logic               i_clk,        // Machine clock
	input  wire logic               i_nrst,       // Async reset, low
	input  wire p0g_pkg::p0g_pins_t i_pad_out,    // Device drive value
	input  wire p0g_pkg::p0g_pins_t i_pad_oe,     // Device drives pin
	input  wire p0g_pkg::p0g_pins_t i_pullup_en,  // Pull-up connected
	input  wire p0g_pkg::p0g_pins_t i_ext_en,     // External source on
	input  wire p0g_pkg::p0g_pins_t i_ext_val,    // External source level
	output      p0g_pkg::p0g_pins_t o_pad_in      // Resolved pin level
);
	import p0g_pkg::*;
	p0g_pins_t flt_q;  // Open-pin pattern

	// Open pins wander so a stale level never passes for a real one
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flt_q <= 4'h5;
		end else begin
			flt_q <= ~flt_q;
		end
	end

	// Wire resolution per pin: drive, external, pull-up, open
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (i_pad_oe[i]) begin
				o_pad_in[i] = i_pad_out[i];
			end else if (i_ext_en[i]) begin
				o_pad_in[i] = i_ext_val[i];
			end else if (i_pullup_en[i]) begin
				o_pad_in[i] = 1'b1;  // Resistor only while connected
			end else begin
				o_pad_in[i] = flt_q[i];
			end
		end
	end
endmodule : p0g_board

// ---- tb/p0g_port0_test.sv ----
/*
 * Self-checking bench for port 0: register access, pad drive, read
 * paths, peripheral override and standby behaviour.
 * Assumes the single-cycle strobe register bus and the board model.
 */
`timescale 1ns/10ps
`include "p0g_cfg.svh"

module p0g_port0_test;
	import p0g_pkg::*;
	logic      i_clk, i_nrst, i_wr, i_rd, i_rmw;  // Clock, reset, strobes
	p0g_addr_t i_addr;                            // Register address
	p0g_byte_t i_wdata, o_rdata;                  // Bus data
	p0g_pins_t i_pad_in, o_pad_out, o_pad_oe;     // Pad wires
	p0g_pins_t o_pullup_en, o_dig_in, o_analog_en; // Pad controls
	p0g_pins_t i_periph_oe, i_periph_val;         // Peripheral drive
	p0g_pins_t ext_en, ext_val;                   // Board source
	logic      i_standby, i_spl, i_irq5;          // Standby controls
	int        err_total, num_checks;             // Tallies
	int        pin_idx;                           // Pin of one disable bit

	p0g_port0 p0g_port0_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_rmw(i_rmw), .o_rdata(o_rdata),
		.i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
		.o_pullup_en(o_pullup_en), .o_dig_in(o_dig_in), .o_analog_en(o_analog_en),
		.i_periph_oe(i_periph_oe), .i_periph_val(i_periph_val), .i_standby(i_standby),
		.i_standby_pin_state_bit(i_spl), .i_ext_irq_line_5_en(i_irq5));
	p0g_board p0g_board_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_pad_out(o_pad_out),
		.i_pad_oe(o_pad_oe), .i_pullup_en(o_pullup_en), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_pad_in(i_pad_in));

	// Free-running 250 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// Single comparison, reported at once
	task automatic chk(input p0g_byte_t got, input p0g_byte_t exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// One write cycle; a gap edge follows so strobes never double up
	task automatic wr(input p0g_addr_t a, input p0g_byte_t d);
		@(posedge i_clk);
		i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// One read cycle; data checked mid-cycle after the strobe, ends on a rising edge
	task automatic rd(input p0g_addr_t a, input logic m, input p0g_byte_t e, input p0g_byte_t k);
		@(posedge i_clk);
		i_addr <= a; i_rd <= 1'b1; i_rmw <= m;
		@(posedge i_clk);
		i_rd <= 1'b0; i_rmw <= 1'b0;
		@(negedge i_clk);
		chk(o_rdata & k, e & k, "read");
		@(posedge i_clk);
	endtask : rd

	// Let pad registers and the board settle, then compare pads
	task automatic pads(input p0g_pins_t oe, input p0g_pins_t val, input p0g_pins_t pu);
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		chk({4'h0, o_pad_oe}, {4'h0, oe}, "pad enable");
		chk({4'h0, o_pad_out & oe}, {4'h0, val & oe}, "pad value");
		chk({4'h0, o_pullup_en}, {4'h0, pu}, "pull-up");
		@(posedge i_clk);
	endtask : pads

	// Verdict, shared by the main sequence and the watchdog
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Hang guard, well above the 150 or so cycles the tests need
	initial begin
		#40000;
		err_total++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		err_total = 0; num_checks = 0;
		i_nrst = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_rmw = 1'b0;
		i_addr = 4'h0; i_wdata = 8'h00; i_periph_oe = 4'h0; i_periph_val = 4'h0;
		i_standby = 1'b0; i_spl = 1'b0; i_irq5 = 1'b0; ext_en = 4'hf; ext_val = 4'ha;
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		// Reset values and an unmapped place
		rd(`P0G_OFF_DIR, 1'b0, 8'h00, 8'hff);
		rd(`P0G_OFF_AIDR, 1'b0, 8'h00, 8'hff);
		rd(`P0G_OFF_PUL, 1'b0, 8'h00, 8'hff);
		rd(`P0G_OFF_DATA, 1'b0, 8'h00, 8'hff);
		wr(4'h9, 8'hff);
		rd(4'h9, 1'b0, 8'h00, 8'hff);
		rd(`P0G_OFF_DIR, 1'b0, 8'h00, 8'hff);
		chk({4'h0, o_analog_en}, 8'h0f, "analog after reset");
		pads(4'h0, 4'h0, 4'h0);
		$display("test reset done");
		// Input mode: latch kept off the pin, reads split by kind
		wr(`P0G_OFF_DATA, 8'h5f);
		wr(`P0G_OFF_AIDR, 8'hff);
		pads(4'h0, 4'h0, 4'h0);
		chk({4'h0, o_analog_en}, 8'h00, "analog off");
		chk({4'h0, o_dig_in}, 8'h0a, "digital in");
		rd(`P0G_OFF_AIDR, 1'b0, 8'h33, 8'hff);
		rd(`P0G_OFF_DATA, 1'b0, 8'ha0, 8'hff);
		rd(`P0G_OFF_DATA, 1'b1, 8'h50, 8'hff);
		$display("test input done");
		// Disable bit to pin mapping, one bit at a time
		ext_val <= 4'hf;
		for (int b = 0; b < `P0G_DATA_W; b++) begin
			if (((`P0G_AIDR_MASK >> b) & 1) != 0) begin
				// Bits 0,1,4,5 belong to pins 4,5,6,7
				pin_idx = (b & 1) | ((b >> 1) & 2);
				wr(`P0G_OFF_AIDR, 8'h01 << b);
				rd(`P0G_OFF_DATA, 1'b0, 8'h10 << pin_idx, 8'hff);
				chk({4'h0, ~o_analog_en}, 8'h01 << pin_idx, "analog map");
			end
		end
		$display("test mapping done");
		// Output mode with pull-up dropped on low pins
		ext_en <= 4'h0;
		wr(`P0G_OFF_AIDR, 8'h33);
		wr(`P0G_OFF_PUL, 8'hf0);
		wr(`P0G_OFF_DIR, 8'hf0);
		pads(4'hf, 4'h5, 4'h5);
		rd(`P0G_OFF_DATA, 1'b0, 8'h50, 8'hff);
		wr(`P0G_OFF_DATA, 8'ha0);
		pads(4'hf, 4'ha, 4'ha);
		$display("test output done");
		// Peripheral takes pins 5 and 4 over latch and direction
		i_periph_oe <= 4'h3; i_periph_val <= 4'h1;
		pads(4'hf, 4'h9, 4'h9);
		rd(`P0G_OFF_DATA, 1'b0, 8'h90, 8'hff);
		rd(`P0G_OFF_DATA, 1'b1, 8'ha0, 8'hff);
		wr(`P0G_OFF_DIR, 8'h00);
		pads(4'h3, 4'h1, 4'hd);
		i_periph_oe <= 4'h0;
		wr(`P0G_OFF_PUL, 8'h00);
		$display("test peripheral done");
		// Standby with isolation, pin 5 kept open then blocked
		ext_en <= 4'hf; ext_val <= 4'hf;
		i_standby <= 1'b1; i_spl <= 1'b1; i_irq5 <= 1'b1;
		pads(4'h0, 4'h0, 4'h0);
		chk({4'h0, o_dig_in}, 8'h02, "kept input");
		rd(`P0G_OFF_DATA, 1'b0, 8'h20, 8'hff);
		rd(`P0G_OFF_STAT, 1'b0, 8'h02, 8'h03);
		i_irq5 <= 1'b0;
		pads(4'h0, 4'h0, 4'h0);
		chk({4'h0, o_dig_in}, 8'h00, "blocked input");
		// Standby without isolation holds the driven levels
		i_standby <= 1'b0; i_spl <= 1'b0; ext_en <= 4'h0;
		wr(`P0G_OFF_DIR, 8'hf0);
		pads(4'hf, 4'ha, 4'h0);
		i_standby <= 1'b1;
		wr(`P0G_OFF_DATA, 8'h50);
		wr(`P0G_OFF_DIR, 8'h00);
		pads(4'hf, 4'ha, 4'h0);
		rd(`P0G_OFF_STAT, 1'b0, 8'h01, 8'h03);
		i_standby <= 1'b0;
		pads(4'h0, 4'h0, 4'h0);
		$display("test standby done");
		tally_and_finish();
	end
endmodule : p0g_port0_test
